// ### shared/iwh_defines.vh
`ifndef IWH_DEFINES_VH
`define IWH_DEFINES_VH

// register addresses
`define IWH_STATUS_ADDR   7'h0a
`define IWH_INTERRUPT_CONTROL_ADDR     7'h0b

// interrupt control fields
`define IWH_GIE_BIT       0
`define IWH_EIE_BIT       1
`define IWH_TIE_BIT       2
`define IWH_CIE_BIT       3
`define IWH_EIF_BIT       4
`define IWH_TOF_BIT       5
`define IWH_CDF_BIT       6
`define IWH_INTERRUPT_CONTROL_RESET    8'h00

// status fields
`define IWH_PDF_BIT       4
`define IWH_TO_BIT        5

// vectors
`define IWH_VEC_EXT       10'h004
`define IWH_VEC_TMR       10'h008
`define IWH_VEC_CONV      10'h00c

// timing
`define IWH_INSTR_DIV     2'h3
`define IWH_WAKE_DELAY    1024
`define IWH_DOG_BITS      16
`define IWH_PRE_BITS      7

`endif

// ### sim/iwh_core_model.sv
module iwh_core_model (
   // clock and design status
   input  wire logic clk_i,
   input  wire logic core_run_i,
   input  wire logic vector_call_i,
   // scenario knobs
   input  wire logic clear_en_i,
   input  wire logic double_i,
   input  wire logic full_i,
   // core requests
   output var  logic phase_two_tick_o,
   output var  logic stack_full_o,
   output var  logic return_from_irq_op_o,
   output var  logic dog_clear_op_o,
   output var  logic dog_clear_first_op_o,
   output var  logic dog_clear_second_op_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned cyc = 0;
   int unsigned ret_cnt = 0;
   logic        clr;

   initial
   begin
      {phase_two_tick_o, stack_full_o, return_from_irq_op_o} = 3'h0;
      {dog_clear_op_o, dog_clear_first_op_o, dog_clear_second_op_o} = 3'h0;
   end

   // requests change only at the falling edge, one cycle wide except stack_full_o, which follows full_i
   always @(negedge clk_i)
   begin
      clr = clear_en_i && core_run_i;
      cyc <= cyc + 1;
      phase_two_tick_o <= core_run_i && (cyc % 4 == 3);
      stack_full_o <= full_i;
      dog_clear_op_o <= clr && !double_i && (cyc % 64 == 0);
      dog_clear_first_op_o <= clr && double_i && (cyc % 64 == 0);
      dog_clear_second_op_o <= clr && double_i && (cyc % 64 == 2);
      // service routine returns twenty cycles after the call
      if (vector_call_i)
         ret_cnt <= 20;
      else if (ret_cnt != 0)
         ret_cnt <= ret_cnt - 1;
      return_from_irq_op_o <= (ret_cnt == 1);
   end
endmodule // iwh_core_model

// ### sim/iwh_top_assertions.sv
module iwh_top_assertions (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // core side inputs
   input  wire logic       phase_two_tick_i,
   input  wire logic       stack_full_i,
   input  wire logic       dog_clear_op_i,
   input  wire logic       halt_op_i,
   input  wire logic       opt_dog_enable_i,
   input  wire logic       opt_double_clear_i,
   input  wire logic       opt_rc_sysosc_i,
   // watched outputs
   input  wire logic       clock_out_pin_o,
   input  wire logic       vector_call_o,
   input  wire logic [9:0] vector_addr_o,
   input  wire logic       chip_reset_o,
   input  wire logic       warm_reset_o,
   input  wire logic       core_run_o,
   input  wire logic       sys_osc_run_o,
   input  wire logic       halted_o,
   input  wire logic       timeout_flag_o,
   input  wire logic       powerdown_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   chk_call_on_tick: assert property (vector_call_o |->
      $past(phase_two_tick_i) && !$past(stack_full_i))
      else $error("vector call without tick or with stack full");
   chk_vector_table: assert property (vector_call_o |->
      vector_addr_o inside {10'h004, 10'h008, 10'h00c})
      else $error("vector address outside the table");
   chk_halt_stops: assert property (halted_o |->
      !sys_osc_run_o && !core_run_o)
      else $error("oscillator or core running in halt");
   chk_halt_flags: assert property ($rose(halted_o) |->
      powerdown_flag_o && !timeout_flag_o)
      else $error("flags wrong on halt entry");
   chk_wake_delay: assert property ($fell(halted_o) |->
      !core_run_o [*8] ##[1:2] core_run_o)
      else $error("wake delay length wrong");
   chk_warm_reset: assert property (warm_reset_o |=>
      timeout_flag_o && !halted_o)
      else $error("warm reset without timeout or wake");
   chk_dog_clear: assert property (dog_clear_op_i && core_run_o &&
      opt_dog_enable_i && !opt_double_clear_i && !halt_op_i |=>
      !powerdown_flag_o && !timeout_flag_o)
      else $error("clear instruction left a flag set");
   chk_clk_out: assert property (@(posedge clk_i)
      disable iff (reset_i || halted_o || chip_reset_o)
      opt_rc_sysosc_i && core_run_o && $rose(clock_out_pin_o) |=>
      clock_out_pin_o ##1 !clock_out_pin_o [*2] ##1 clock_out_pin_o)
      else $error("clock out is not clk/4");
endmodule // iwh_top_assertions

bind iwh_top iwh_top_assertions u_chk (.*);

// ### sim/iwh_top_test.sv
module iwh_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, reset_i = 1, ce_i = 1, hw_init_pin_n_i = 1;
   logic ext_irq_pin_n_i = 1, dog_osc_i = 0, timer_ovf_i = 0;
   logic conv_done_i = 0, reg_wr_i = 0, halt_op_i = 0;
   logic opt_dog_enable_i = 1, opt_dog_use_rc_i = 1, opt_double_clear_i = 0;
   logic opt_rc_sysosc_i = 1, clr_en = 1, full = 0;
   logic [2:0] opt_dog_prescale_i = 3'h0;
   logic [6:0] reg_addr_i = 7'h00;
   logic [7:0] reg_wdata_i = 8'h00, port_a_i = 8'hff, opt_wake_mask_i = 8'h00;
   wire  phase_two_tick_i, stack_full_i, return_from_irq_op_i, dog_clear_op_i;
   wire  dog_clear_first_op_i, dog_clear_second_op_i, clock_out_pin_o;
   wire  vector_call_o, chip_reset_o, warm_reset_o, core_run_o, halted_o;
   wire  sys_osc_run_o, timeout_flag_o, powerdown_flag_o;
   wire  [7:0] reg_rdata_o;
   wire  [9:0] vector_addr_o;
   int   err_count = 0, samples_checked = 0, cyc = 0, ncall = 0, nrst = 0;

   iwh_top #(.DOG_BITS(4), .WAKE_DELAY(8)) u_dut (.*);
   iwh_core_model u_core (.clk_i(clk_i), .core_run_i(core_run_o),
      .vector_call_i(vector_call_o), .clear_en_i(clr_en),
      .double_i(opt_double_clear_i), .full_i(full),
      .phase_two_tick_o(phase_two_tick_i), .stack_full_o(stack_full_i),
      .return_from_irq_op_o(return_from_irq_op_i),
      .dog_clear_op_o(dog_clear_op_i),
      .dog_clear_first_op_o(dog_clear_first_op_i),
      .dog_clear_second_op_o(dog_clear_second_op_i));

   always #25 clk_i = ~clk_i;
   always #263 dog_osc_i = ~dog_osc_i;
   always @(posedge clk_i)
   begin
      cyc++;
      ncall += int'(vector_call_o === 1'b1);
      nrst += int'(chip_reset_o === 1'b1);
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cmp(string n, logic [9:0] e, logic [9:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic settle(int k);
      repeat (k) @(negedge clk_i);
   endtask

   task automatic wr_reg(logic [6:0] a, logic [7:0] d);
      @(negedge clk_i);
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
      @(negedge clk_i);
      reg_wr_i = 0;
   endtask

   task automatic rd_reg(logic [6:0] a, logic [7:0] e);
      @(negedge clk_i);
      reg_addr_i = a;
      settle(2);
      cmp("register", {2'h0, e}, {2'h0, reg_rdata_o});
   endtask

   // waits for a vector call, bounded, and checks its address
   task automatic wait_vec(logic [9:0] e);
      int n;
      n = 0;
      while (vector_call_o !== 1'b1 && n < 300)
      begin
         @(negedge clk_i);
         n++;
      end
      cmp("vector", e, (n < 300) ? vector_addr_o : 10'h3ff);
      @(negedge clk_i);
   endtask

   // waits for the halt state to end, returns cycles spent
   task automatic wait_wake(output int n);
      n = 0;
      while (halted_o !== 1'b0 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
   endtask

   task automatic t_regs();
      rd_reg(7'h0b, 8'h00);
      rd_reg(7'h20, 8'h00);
      wr_reg(7'h0b, 8'h0e);
      rd_reg(7'h0b, 8'h0e);
      $display("test registers done");
   endtask

   task automatic t_irq();
      int n0;
      full = 1;
      wr_reg(7'h0b, 8'h00);
      {timer_ovf_i, conv_done_i, ext_irq_pin_n_i} = 3'b110;
      @(negedge clk_i);
      {timer_ovf_i, conv_done_i} = 2'b00;
      settle(6);
      rd_reg(7'h0b, 8'h70);
      wr_reg(7'h0b, 8'h7f);
      n0 = ncall;
      settle(40);
      cmp("calls while full", 10'(n0), 10'(ncall));
      full = 0;
      wait_vec(10'h004);
      rd_reg(7'h0b, 8'h6e);
      wait_vec(10'h008);
      wait_vec(10'h00c);
      rd_reg(7'h0b, 8'h0e);
      ext_irq_pin_n_i = 1;
      wr_reg(7'h0b, 8'h00);
      $display("test interrupts done");
   endtask

   task automatic t_halt();
      int n;
      opt_wake_mask_i = 8'h01;
      conv_done_i = 1;
      @(negedge clk_i);
      {conv_done_i, halt_op_i} = 2'b01;
      @(negedge clk_i);
      halt_op_i = 0;
      settle(2);
      cmp("halted", 10'h001, {9'h0, halted_o});
      cmp("powerdown", 10'h001, {9'h0, powerdown_flag_o});
      {conv_done_i, port_a_i[1]} = 2'b10;
      @(negedge clk_i);
      conv_done_i = 0;
      settle(30);
      cmp("still halted", 10'h001, {9'h0, halted_o});
      port_a_i[0] = 0;
      wait_wake(n);
      settle(12);
      cmp("resumed", 10'h001, {9'h0, core_run_o});
      port_a_i = 8'hff;
      settle(70);
      cmp("powerdown cleared", 10'h000, {9'h0, powerdown_flag_o});
      wr_reg(7'h0b, 8'h00);
      $display("test halt done");
   endtask

   task automatic t_dog();
      int n, r0;
      clr_en = 0;
      r0 = nrst;
      settle(180);
      cmp("dog reset", 10'h001, 10'(nrst > r0));
      cmp("timeout", 10'h001, {9'h0, timeout_flag_o});
      clr_en = 1;
      settle(70);
      halt_op_i = 1;
      @(negedge clk_i);
      halt_op_i = 0;
      settle(1);
      cmp("timeout on halt", 10'h000, {9'h0, timeout_flag_o});
      wait_wake(n);
      cmp("dog period", 10'h001, 10'(n >= 140 && n <= 200));
      cmp("warm timeout", 10'h001, {9'h0, timeout_flag_o});
      rd_reg(7'h0a, 8'h30);
      opt_double_clear_i = 1;
      r0 = nrst;
      settle(400);
      cmp("double clear", 10'(r0), 10'(nrst));
      opt_double_clear_i = 0;
      wr_reg(7'h0b, 8'h0f);
      hw_init_pin_n_i = 0;
      settle(4);
      cmp("init reset", 10'h001, {9'h0, chip_reset_o});
      hw_init_pin_n_i = 1;
      settle(14);
      rd_reg(7'h0b, 8'h00);
      $display("test watchdog done");
   endtask

   // disabled dog, instruction clock, prescaler, clock out off
   task automatic t_opts();
      int n, r0;
      {opt_dog_enable_i, opt_wake_mask_i, halt_op_i} = {1'b0, 8'h01, 1'b1};
      @(negedge clk_i);
      {halt_op_i, opt_rc_sysosc_i} = 2'b00;
      settle(4);
      port_a_i[0] = 0;
      wait_wake(n);
      port_a_i[0] = 1;
      r0 = nrst;
      settle(250);
      cmp("disabled dog reset", 10'(r0), 10'(nrst));
      cmp("disabled clear", 10'h001, {9'h0, powerdown_flag_o});
      repeat (4)
      begin
         @(negedge clk_i);
         cmp("clock out off", 10'h000, {9'h0, clock_out_pin_o});
      end
      {opt_dog_enable_i, opt_dog_use_rc_i, clr_en, halt_op_i} = 4'b1001;
      @(negedge clk_i);
      halt_op_i = 0;
      settle(150);
      cmp("instr dog halted", 10'h001, {9'h0, halted_o});
      port_a_i[0] = 0;
      wait_wake(n);
      port_a_i[0] = 1;
      r0 = nrst;
      settle(90);
      cmp("instr dog reset", 10'h001, 10'(nrst > r0));
      {opt_dog_use_rc_i, opt_dog_prescale_i, halt_op_i} = {1'b1, 3'h1, 1'b1};
      @(negedge clk_i);
      halt_op_i = 0;
      wait_wake(n);
      cmp("prescaled period", 10'h001, 10'(n >= 300 && n < 400));
      $display("test options done");
   endtask

   initial
   begin
      settle(4);
      reset_i = 0;
      t_regs();
      t_irq();
      t_halt();
      t_dog();
      t_opts();
      summarize();
   end
endmodule // iwh_top_test

// ### src/iwh_dog_counter.v
`include "iwh_defines.vh"

module iwh_dog_counter #(
   parameter DOG_BITS = `IWH_DOG_BITS,
   parameter PRE_BITS = `IWH_PRE_BITS
) (
   // clock and reset
   input  wire                clk_i,
   input  wire                reset_i,
   input  wire                ce_i,
   // control
   input  wire                clear_i,
   input  wire                tick_i,
   input  wire [2:0]          pre_sel_i,
   // result
   output reg                 overflow_o
);

   reg  [PRE_BITS-1:0] pre_r;
   reg  [DOG_BITS-1:0] cnt_r;
   wire [PRE_BITS-1:0] pre_mask;
   wire                pre_done;

   // prescaler stages lengthen the period
   assign pre_mask = ~({PRE_BITS{1'b1}} << pre_sel_i);
   assign pre_done = tick_i && ((pre_r & pre_mask) == pre_mask);

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         pre_r      <= {PRE_BITS{1'b0}};
         cnt_r      <= {DOG_BITS{1'b0}};
         overflow_o <= 1'b0;
      end
      else if (ce_i)
      begin
         overflow_o <= 1'b0;
         if (clear_i)
         begin
            pre_r <= {PRE_BITS{1'b0}};
            cnt_r <= {DOG_BITS{1'b0}};
         end
         else if (tick_i)
         begin
            pre_r <= pre_done ? {PRE_BITS{1'b0}} : pre_r + 1'b1;
            if (pre_done)
            begin
               cnt_r <= cnt_r + 1'b1;
               if (&cnt_r)
                  overflow_o <= 1'b1;
            end
         end
      end
   end

endmodule // iwh_dog_counter

// ### src/iwh_top.v
`include "iwh_defines.vh"

module iwh_top #(
   parameter DOG_BITS   = `IWH_DOG_BITS,
   parameter PRE_BITS   = `IWH_PRE_BITS,
   parameter WAKE_DELAY = `IWH_WAKE_DELAY
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        reset_i,
   input  wire        ce_i,
   // pins
   input  wire        hw_init_pin_n_i,
   input  wire        ext_irq_pin_n_i,
   input  wire [7:0]  port_a_i,
   input  wire        dog_osc_i,
   output reg         clock_out_pin_o,
   // event sources
   input  wire        timer_ovf_i,
   input  wire        conv_done_i,
   // core register access
   input  wire [6:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire [7:0]  reg_wdata_i,
   output reg  [7:0]  reg_rdata_o,
   // core instructions and status
   input  wire        phase_two_tick_i,
   input  wire        stack_full_i,
   input  wire        return_from_irq_op_i,
   input  wire        dog_clear_op_i,
   input  wire        dog_clear_first_op_i,
   input  wire        dog_clear_second_op_i,
   input  wire        halt_op_i,
   // options
   input  wire        opt_dog_enable_i,
   input  wire        opt_dog_use_rc_i,
   input  wire        opt_double_clear_i,
   input  wire        opt_rc_sysosc_i,
   input  wire [2:0]  opt_dog_prescale_i,
   input  wire [7:0]  opt_wake_mask_i,
   // core control
   output reg         vector_call_o,
   output reg  [9:0]  vector_addr_o,
   output reg         chip_reset_o,
   output reg         warm_reset_o,
   output wire        core_run_o,
   output wire        sys_osc_run_o,
   output wire        halted_o,
   output reg         timeout_flag_o,
   output reg         powerdown_flag_o
);

   localparam ST_RUN  = 2'd0;
   localparam ST_HALT = 2'd1;
   localparam ST_WAKE = 2'd2;
   localparam DLY_W   = 11;
   localparam integer     DLY_LAST_I = WAKE_DELAY - 1;
   localparam [DLY_W-1:0] DLY_LAST   = DLY_LAST_I[DLY_W-1:0];

   // pin synchronisers: ext, init, dog osc, port a
   reg  [10:0] sync1_r;
   reg  [10:0] sync2_r;
   reg  [10:0] prev_r;
   wire [10:0] pins_raw;
   wire [10:0] fall;
   wire        init_low;
   wire        osc_rise;

   reg  [1:0]       state_r;
   reg  [1:0]       state_nxt;
   reg  [DLY_W-1:0] dly_r;
   reg  [DLY_W-1:0] dly_nxt;
   reg  [1:0]       div_r;
   reg  [3:0]       en_r;
   reg  [3:0]       en_nxt;
   reg  [2:0]       flg_r;
   reg  [2:0]       flg_nxt;
   reg  [2:0]       halt_flg_r;
   reg              first_r;
   reg              second_r;
   reg              to_nxt;
   reg              pdf_nxt;
   reg  [9:0]       vec_nxt;
   reg  [7:0]       rd_nxt;

   wire [2:0] events;
   wire [2:0] pend;
   wire       service;
   wire       running;
   wire       instr_tick;
   wire       dog_tick;
   wire       dog_ovf;
   wire       ovf_normal;
   wire       ovf_halt;
   wire       clr_single;
   wire       clr_double;
   wire       clr_eff;
   wire       halt_entry;
   wire       dog_clear;
   wire       wake;
   wire       chip_rst;

   assign pins_raw = {port_a_i, dog_osc_i, hw_init_pin_n_i,
                      ext_irq_pin_n_i};
   assign fall     = prev_r & ~sync2_r;
   assign init_low = ~sync2_r[1];
   assign osc_rise = sync2_r[2] & ~prev_r[2];

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sync1_r <= 11'h7ff;
         sync2_r <= 11'h7ff;
         prev_r  <= 11'h7ff;
      end
      else if (ce_i)
      begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // system clock run and instruction clock
   assign running    = (state_r != ST_HALT);
   assign instr_tick = running && (div_r == `IWH_INSTR_DIV);

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         div_r           <= 2'h0;
         clock_out_pin_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (running)
            div_r <= div_r + 2'h1;
         clock_out_pin_o <= opt_rc_sysosc_i & div_r[1];
      end
   end

   // interrupt request logic
   assign events  = {conv_done_i, timer_ovf_i,
                     fall[0]};
   assign pend    = flg_r & en_r[3:1];
   assign service = (state_r == ST_RUN) && phase_two_tick_i &&
                    en_r[`IWH_GIE_BIT] &&
                    !stack_full_i &&
                    (|pend);
   assign chip_rst = init_low | ovf_normal;

   always @*
   begin
      en_nxt  = en_r;
      flg_nxt = flg_r;
      vec_nxt = vector_addr_o;
      if (reg_wr_i && (reg_addr_i == `IWH_INTERRUPT_CONTROL_ADDR))
      begin
         en_nxt  = reg_wdata_i[3:0];
         flg_nxt = reg_wdata_i[6:4];
      end
      if (return_from_irq_op_i)
         en_nxt[`IWH_GIE_BIT] = 1'b1;
      if (service)
      begin
         en_nxt[`IWH_GIE_BIT] = 1'b0;
         if (pend[0])
         begin
            vec_nxt    = `IWH_VEC_EXT;
            flg_nxt[0] = 1'b0;
         end
         else if (pend[1])
         begin
            vec_nxt    = `IWH_VEC_TMR;
            flg_nxt[1] = 1'b0;
         end
         else
         begin
            vec_nxt    = `IWH_VEC_CONV;
            flg_nxt[2] = 1'b0;
         end
      end
      flg_nxt = flg_nxt | events;
      if (chip_rst)
      begin
         en_nxt  = 4'h0;
         flg_nxt = 3'h0;
      end
   end

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         en_r          <= 4'h0;
         flg_r         <= 3'h0;
         vector_call_o <= 1'b0;
         vector_addr_o <= 10'h000;
      end
      else if (ce_i)
      begin
         en_r          <= en_nxt;
         flg_r         <= flg_nxt;
         vector_call_o <= service;
         vector_addr_o <= vec_nxt;
      end
   end

   // watchdog clear instructions
   assign clr_single = (state_r == ST_RUN) && opt_dog_enable_i &&
                       !opt_double_clear_i && dog_clear_op_i;
   assign clr_double = (state_r == ST_RUN) && opt_dog_enable_i &&
                       opt_double_clear_i &&
                       (first_r | dog_clear_first_op_i) &&
                       (second_r | dog_clear_second_op_i);
   assign clr_eff    = clr_single | clr_double;
   assign halt_entry = (state_r == ST_RUN) && halt_op_i;
   assign dog_clear  = init_low | clr_eff | halt_entry;

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         first_r  <= 1'b0;
         second_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (clr_double || init_low || !opt_double_clear_i)
         begin
            first_r  <= 1'b0;
            second_r <= 1'b0;
         end
         else if ((state_r == ST_RUN) && opt_dog_enable_i)
         begin
            first_r  <= first_r | dog_clear_first_op_i;
            second_r <= second_r | dog_clear_second_op_i;
         end
      end
   end

   // watchdog clock source and counter
   assign dog_tick = opt_dog_enable_i &&
                     (opt_dog_use_rc_i ? osc_rise
                                       : instr_tick);

   iwh_dog_counter #(
      .DOG_BITS (DOG_BITS),
      .PRE_BITS (PRE_BITS)
   ) u_dog (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .ce_i       (ce_i),
      .clear_i    (dog_clear),
      .tick_i     (dog_tick),
      .pre_sel_i  (opt_dog_prescale_i),
      .overflow_o (dog_ovf)
   );

   assign ovf_normal = dog_ovf && (state_r != ST_HALT);
   assign ovf_halt   = dog_ovf && (state_r == ST_HALT);

   // status flags, timeout set wins over clear, powerdown clear wins over set
   always @*
   begin
      to_nxt  = timeout_flag_o;
      pdf_nxt = powerdown_flag_o;
      if (halt_entry)
      begin
         to_nxt  = 1'b0;
         pdf_nxt = 1'b1;
      end
      if (clr_eff)
      begin
         to_nxt  = 1'b0;
         pdf_nxt = 1'b0;
      end
      if (dog_ovf)
         to_nxt = 1'b1;
   end

   // halt and wake sequencing
   assign wake = init_low | dog_ovf |
                 (|(fall[10:3] & opt_wake_mask_i)) |
                 (|(flg_r & ~halt_flg_r));

   always @*
   begin
      state_nxt = state_r;
      dly_nxt   = dly_r;
      case (state_r)
         ST_RUN:
         begin
            if (chip_rst)
            begin
               state_nxt = ST_WAKE;
               dly_nxt   = {DLY_W{1'b0}};
            end
            else if (halt_op_i)
               state_nxt = ST_HALT;
         end
         ST_HALT:
         begin
            if (wake)
            begin
               state_nxt = ST_WAKE;
               dly_nxt   = {DLY_W{1'b0}};
            end
         end
         ST_WAKE:
         begin
            if (init_low)
               dly_nxt = {DLY_W{1'b0}};
            else if (dly_r == DLY_LAST)
               state_nxt = ST_RUN;
            else
               dly_nxt = dly_r + 1'b1;
         end
         default:
         begin
            state_nxt = ST_RUN;
            dly_nxt   = {DLY_W{1'b0}};
         end
      endcase
   end

   // register read data
   always @*
   begin
      rd_nxt = 8'h00;
      if (reg_addr_i == `IWH_INTERRUPT_CONTROL_ADDR)
         rd_nxt = {1'b0, flg_r, en_r};
      else if (reg_addr_i == `IWH_STATUS_ADDR)
      begin
         rd_nxt[`IWH_TO_BIT]  = timeout_flag_o;
         rd_nxt[`IWH_PDF_BIT] = powerdown_flag_o;
      end
   end

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_r          <= ST_RUN;
         dly_r            <= {DLY_W{1'b0}};
         halt_flg_r       <= 3'h0;
         timeout_flag_o   <= 1'b0;
         powerdown_flag_o <= 1'b0;
         chip_reset_o     <= 1'b0;
         warm_reset_o     <= 1'b0;
         reg_rdata_o      <= 8'h00;
      end
      else if (ce_i)
      begin
         state_r          <= state_nxt;
         dly_r            <= dly_nxt;
         timeout_flag_o   <= to_nxt;
         powerdown_flag_o <= pdf_nxt;
         chip_reset_o     <= chip_rst;
         warm_reset_o     <= ovf_halt;
         reg_rdata_o      <= rd_nxt;
         if (halt_entry)
            halt_flg_r <= flg_r;
      end
   end

   assign core_run_o    = (state_r == ST_RUN);
   assign sys_osc_run_o = running;
   assign halted_o      = (state_r == ST_HALT);

endmodule // iwh_top
